// ===== rtl/gated_sixteen_bit_timer.sv
// Gated sixteen bit timer with prescaler, gate and APB registers
// Overview of operation
// - Sixteen bit counter, byte writes update immediately
// - Source select: instruction clock or external pin
// - Counter mode counts external rising edges
// - Falling edge needed before first counted rise
// - Prescaler divides by 1, 2, 4, 8
// - Prescaler hidden; cleared on count byte write
// - Oscillator enable starts crystal, runs in sleep
// - Oscillator on forces pins input, data reads 0
// - Sync disable counts unsynchronized, also during sleep
// - Sync mode switch may lose or add one
// - Byte reads return valid value when async
// - Gate source: gate pin or comparator two
// - Gate ignored unless gate enable set
// - Gate invert flips polarity of either source
// - Rollover sets overflow flag
// - Interrupt needs overflow, peripheral, global enables
// - Sleep wake on overflow, vector when global
// - Time base for capture and compare match
// - Special trigger clears count, no overflow flag
// - Byte write beats same-cycle special trigger
// - Control bit layout, all reset zero
module gated_sixteen_bit_timer (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gtimer_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic i_external_count_input,
    input wire logic i_crystal_osc_in_pin,
    input wire logic i_gate_pin,
    input wire logic i_synced_comparator_output,
    input wire logic i_capture_event,
    input wire logic i_sleep,
    output logic o_crystal_osc_out_pin,
    output logic o_crystal_osc_enable,
    output logic o_port_c_dir_bit0,
    output logic o_port_c_dir_bit1,
    output logic o_port_c_data_bit0,
    output logic o_port_c_data_bit1,
    output logic o_irq,
    output logic o_wake,
    output logic [31:0] o_vector,
    output logic o_special_event
);
    import gtimer_pkg::*;

    typedef enum logic [1:0] {
        ARM_WAIT_LOW = 2'b00,
        ARM_WAIT_RISE = 2'b01,
        ARM_READY = 2'b10
    } arm_t;

    logic [7:0] ctrl_ff;
    logic [15:0] count_ff;
    logic [2:0] presc_ff;
    logic [1:0] flags_ff;
    logic [2:0] ien_ff;
    logic [15:0] cc_ff;
    logic [1:0] cc_mode_ff;
    logic gate_sel_ff;
    logic [7:0] port_ff;
    logic ext_s1_ff;
    logic ext_s2_ff;
    logic ext_prev_ff;
    logic nsync_prev_ff;
    logic spurious_ff;
    arm_t arm_ff;
    logic [15:0] rd_hold_ff;

    logic wr_en;
    logic rd_en;
    logic wr_lo;
    logic wr_hi;
    logic cnt_wr;
    logic ext_level;
    logic ext_rise;
    logic src_tick;
    logic gate_raw;
    logic gate_ok;
    logic [2:0] presc_mask;
    logic presc_out;
    logic inc;
    logic ovf;
    logic match;
    logic special;
    logic counting_ok;
    logic ctrl_on;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign wr_lo = wr_en && (paddr == ADDR_CNT_LO);
    assign wr_hi = wr_en && (paddr == ADDR_CNT_HI);
    assign cnt_wr = wr_lo || wr_hi;
    assign ctrl_on = ctrl_ff[CTRL_ON];

    // Sleep stops the synchroniser path; async mode keeps counting
    assign counting_ok = ctrl_on && (!i_sleep || ctrl_ff[CTRL_NSYNC]);

    // External level: crystal pin when oscillator runs, else count pin
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
        end else begin
            ext_s1_ff <= ctrl_ff[CTRL_OSC] ? i_crystal_osc_in_pin
                                           : i_external_count_input;
            ext_s2_ff <= ext_s1_ff;
        end
    end

    // Async mode samples the pin directly, one cycle earlier; the
    // different latency is why a mode change may skip or add one
    assign ext_level = ctrl_ff[CTRL_NSYNC] ? ext_s1_ff : ext_s2_ff;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            ext_prev_ff <= 1'b0;
            nsync_prev_ff <= 1'b0;
            spurious_ff <= 1'b0;
        end else begin
            ext_prev_ff <= ext_level;
            nsync_prev_ff <= ctrl_ff[CTRL_NSYNC];
            spurious_ff <= nsync_prev_ff && !ctrl_ff[CTRL_NSYNC]
                && ext_level;
        end
    end

    assign ext_rise = ext_level && !ext_prev_ff;

    // Falling-edge arming before first counted rise
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            arm_ff <= ARM_WAIT_LOW;
        end else if (cnt_wr) begin
            arm_ff <= ARM_WAIT_LOW;
        end else if (!ctrl_on) begin
            if (ext_level) begin
                arm_ff <= ARM_WAIT_RISE;
            end
        end else begin
            case (arm_ff)
                ARM_WAIT_LOW: begin
                    if (ext_prev_ff && !ext_level) begin
                        arm_ff <= ARM_READY;
                    end
                end
                ARM_WAIT_RISE: begin
                    // High at disable: low now means a missed fall
                    arm_ff <= ext_level ? ARM_READY : ARM_WAIT_LOW;
                end
                default: arm_ff <= ARM_READY;
            endcase
        end
    end

    // Instruction clock tick every fourth system cycle
    logic [1:0] q_ff;
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            q_ff <= 2'h0;
        end else begin
            q_ff <= q_ff + 2'h1;
        end
    end

    always_comb begin
        if (ctrl_ff[CTRL_CS]) begin
            src_tick = ext_rise && (arm_ff == ARM_READY);
            if (spurious_ff) begin
                src_tick = 1'b1;
            end
        end else begin
            src_tick = (q_ff == ICLK_LAST) && !i_sleep;
        end
    end

    // Gate path
    assign gate_raw = gate_sel_ff ? i_synced_comparator_output
                                  : i_gate_pin;
    assign gate_ok = !ctrl_ff[CTRL_GE]
        || (gate_raw ^ ctrl_ff[CTRL_GINV]);

    // Prescaler: binary counter, masked all-ones compare selects division
    always_comb begin
        case (ctrl_ff[CTRL_PS_LO +: 2])
            2'h0: presc_mask = 3'h0;
            2'h1: presc_mask = 3'h1;
            2'h2: presc_mask = 3'h3;
            default: presc_mask = 3'h7;
        endcase
    end
    // Masked compare: a ratio change never stalls the divider
    assign presc_out = src_tick
        && ((presc_ff & presc_mask) == presc_mask);

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            presc_ff <= 3'h0;
        end else if (cnt_wr) begin
            presc_ff <= 3'h0;
        end else if (counting_ok && gate_ok && src_tick) begin
            presc_ff <= presc_out ? 3'h0 : presc_ff + 3'h1;
        end
    end

    assign inc = counting_ok && gate_ok && presc_out;
    assign ovf = inc && (count_ff == CNT_MAX);
    assign match = (cc_mode_ff[1]) && (count_ff == cc_ff);
    // Async counting never fires the special trigger
    assign special = match && (cc_mode_ff == CC_SPECIAL)
        && !ctrl_ff[CTRL_NSYNC];

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            count_ff <= 16'h0000;
        end else if (wr_lo) begin
            count_ff[7:0] <= pwdata[7:0];
        end else if (wr_hi) begin
            count_ff[15:8] <= pwdata[7:0];
        end else if (special) begin
            count_ff <= 16'h0000;
        end else if (inc) begin
            count_ff <= count_ff + 16'h0001;
        end
    end

    // Register reads see a system-clock snapshot, never a moving value
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rd_hold_ff <= 16'h0000;
        end else begin
            rd_hold_ff <= count_ff;
        end
    end

    // Control register
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_ff <= CTRL_RST;
        end else if (wr_en && paddr == ADDR_CTRL) begin
            ctrl_ff <= pwdata[7:0];
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            ien_ff <= 3'h0;
        end else if (wr_en && paddr == ADDR_IEN) begin
            ien_ff <= pwdata[2:0];
        end
    end

    // Mode bits ride above the high compare byte
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            cc_ff <= 16'h0000;
            cc_mode_ff <= CC_OFF;
        end else if (wr_en && paddr == ADDR_CC_LO) begin
            cc_ff[7:0] <= pwdata[7:0];
        end else if (wr_en && paddr == ADDR_CC_HI) begin
            cc_ff[15:8] <= pwdata[7:0];
            cc_mode_ff <= pwdata[CC_MODE_LO +: 2];
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            gate_sel_ff <= 1'b0;
        end else if (wr_en && paddr == ADDR_GSEL) begin
            gate_sel_ff <= pwdata[0];
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            port_ff <= PORT_RST;
        end else if (wr_en && paddr == ADDR_PORT) begin
            port_ff <= pwdata[7:0];
        end
    end

    // Capture copies the count into the capture pair
    logic [15:0] capt_ff;
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            capt_ff <= 16'h0000;
        end else if (i_capture_event && cc_mode_ff == CC_CAPTURE) begin
            capt_ff <= count_ff;
        end
    end

    // Flags: hardware set wins over software clear (write one to clear)
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            flags_ff <= 2'h0;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if (wr_en && paddr == ADDR_FLAGS && pwdata[b]) begin
                    flags_ff[b] <= 1'b0;
                end
            end
            if (ovf) begin
                flags_ff[FLG_OVF] <= 1'b1;
            end
            if (match) begin
                flags_ff[FLG_CMP] <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_irq <= 1'b0;
            o_wake <= 1'b0;
            o_vector <= 32'h00000000;
            o_special_event <= 1'b0;
        end else begin
            o_irq <= flags_ff[FLG_OVF] && (&ien_ff);
            o_wake <= flags_ff[FLG_OVF] && ctrl_on
                && ien_ff[IEN_OVF] && ien_ff[IEN_PERI];
            o_vector <= ien_ff[IEN_GLOB] ? ISR_VECTOR : 32'h00000000;
            o_special_event <= special;
        end
    end

    // Oscillator and pin override
    assign o_crystal_osc_enable = ctrl_ff[CTRL_OSC];
    assign o_crystal_osc_out_pin = ctrl_ff[CTRL_OSC]
        && !i_crystal_osc_in_pin;
    assign o_port_c_dir_bit0 = ctrl_ff[CTRL_OSC] | port_ff[PORT_DIR];
    assign o_port_c_dir_bit1 = ctrl_ff[CTRL_OSC] | port_ff[PORT_DIR + 1];
    assign o_port_c_data_bit0 = !ctrl_ff[CTRL_OSC] & port_ff[PORT_DAT];
    assign o_port_c_data_bit1 = !ctrl_ff[CTRL_OSC] & port_ff[PORT_DAT + 1];

    // Read mux
    always_comb begin
        prdata = 32'h00000000;
        pslverr = 1'b0;
        if (rd_en) begin
            if (paddr == ADDR_CTRL) begin
                prdata = {24'h0, ctrl_ff};
            end else if (paddr == ADDR_CNT_LO) begin
                prdata = {24'h0, rd_hold_ff[7:0]};
            end else if (paddr == ADDR_CNT_HI) begin
                prdata = {24'h0, rd_hold_ff[15:8]};
            end else if (paddr == ADDR_FLAGS) begin
                prdata = {30'h0, flags_ff};
            end else if (paddr == ADDR_IEN) begin
                prdata = {29'h0, ien_ff};
            end else if (paddr == ADDR_CC_LO) begin
                prdata = {24'h0, cc_mode_ff == CC_CAPTURE ? capt_ff[7:0]
                                                          : cc_ff[7:0]};
            end else if (paddr == ADDR_CC_HI) begin
                prdata = {22'h0, cc_mode_ff, cc_mode_ff == CC_CAPTURE
                    ? capt_ff[15:8] : cc_ff[15:8]};
            end else if (paddr == ADDR_GSEL) begin
                prdata = {31'h0, gate_sel_ff};
            end else if (paddr == ADDR_PORT) begin
                prdata = {24'h0, 2'h0, o_port_c_dir_bit1, o_port_c_dir_bit0,
                    port_ff[3:2], o_port_c_data_bit1,
                    o_port_c_data_bit0};
            end else begin
                pslverr = 1'b1;
            end
        end
    end
endmodule // gated_sixteen_bit_timer

// ===== rtl/gtimer_pkg.sv
// Constants shared by the gated sixteen bit timer
package gtimer_pkg;
    localparam int APB_AW = 8;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CNT_LO = 8'h04;
    localparam logic [7:0] ADDR_CNT_HI = 8'h08;
    localparam logic [7:0] ADDR_FLAGS = 8'h0c;
    localparam logic [7:0] ADDR_IEN = 8'h10;
    localparam logic [7:0] ADDR_CC_LO = 8'h14;
    localparam logic [7:0] ADDR_CC_HI = 8'h18;
    localparam logic [7:0] ADDR_GSEL = 8'h1c;
    localparam logic [7:0] ADDR_PORT = 8'h20;
    // Control register fields
    localparam int CTRL_ON = 0;
    localparam int CTRL_CS = 1;
    localparam int CTRL_NSYNC = 2;
    localparam int CTRL_OSC = 3;
    localparam int CTRL_PS_LO = 4;
    localparam int CTRL_GE = 6;
    localparam int CTRL_GINV = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // Enable register fields
    localparam int IEN_OVF = 0;
    localparam int IEN_PERI = 1;
    localparam int IEN_GLOB = 2;
    // Flag register fields
    localparam int FLG_OVF = 0;
    localparam int FLG_CMP = 1;
    // Capture/compare mode field
    localparam logic [1:0] CC_OFF = 2'h0;
    localparam logic [1:0] CC_CAPTURE = 2'h1;
    localparam logic [1:0] CC_COMPARE = 2'h2;
    localparam logic [1:0] CC_SPECIAL = 2'h3;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [31:0] ISR_VECTOR = 32'h00000004;
    localparam logic [7:0] PORT_RST = 8'h00;
    // Port latch fields and capture/compare mode field position
    localparam int PORT_DAT = 0;
    localparam int PORT_DIR = 4;
    localparam int CC_MODE_LO = 8;
    // Instruction clock: last phase of four system cycles
    localparam logic [1:0] ICLK_LAST = 2'h3;
endpackage : gtimer_pkg

// ===== verification/gtimer_assertions.sv
// Port-level checker for the gated sixteen bit timer
module gtimer_assertions
    import gtimer_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic [gtimer_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic i_crystal_osc_in_pin,
    input wire logic o_crystal_osc_out_pin,
    input wire logic o_crystal_osc_enable,
    input wire logic o_port_c_dir_bit0,
    input wire logic o_port_c_dir_bit1,
    input wire logic o_port_c_data_bit0,
    input wire logic o_port_c_data_bit1,
    input wire logic o_irq,
    input wire logic o_wake,
    input wire logic [31:0] o_vector
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);
    logic wr_on;
    logic wr_ctrl;
    logic wr_ien;
    assign wr_on = psel && penable && pready && pwrite;
    assign wr_ctrl = wr_on && paddr == ADDR_CTRL;
    assign wr_ien = wr_on && paddr == ADDR_IEN;
    osc_dir_a: assert property (o_crystal_osc_enable |->
        o_port_c_dir_bit0 && o_port_c_dir_bit1) else $error("osc pin dir");
    osc_data_a: assert property (o_crystal_osc_enable |->
        !o_port_c_data_bit0 && !o_port_c_data_bit1) else $error("osc data");
    osc_en_wr_a: assert property (wr_ctrl |=>
        o_crystal_osc_enable == $past(pwdata[CTRL_OSC]))
        else $error("osc enable not written");
    osc_out_a: assert property (o_crystal_osc_out_pin ==
        (o_crystal_osc_enable && !i_crystal_osc_in_pin))
        else $error("osc amplifier output");
    irq_vec_a: assert property (o_irq |-> o_vector == ISR_VECTOR)
        else $error("irq without vector");
    vec_wr_a: assert property (wr_ien |=> ##1 o_vector ==
        ($past(pwdata[IEN_GLOB], 2) ? ISR_VECTOR : 32'h0))
        else $error("vector does not follow global enable");
    irq_off_a: assert property (wr_ien && !pwdata[IEN_OVF]
        |=> ##1 !o_irq) else $error("irq while disabled");
    wake_off_a: assert property (wr_ctrl && !pwdata[CTRL_ON]
        |=> ##1 !o_wake) else $error("wake while timer off");
endmodule // gtimer_assertions

bind gated_sixteen_bit_timer gtimer_assertions chk_u (.i_mclk, .i_nrst,
    .psel, .penable, .pwrite, .pready, .paddr, .pwdata,
    .i_crystal_osc_in_pin, .o_crystal_osc_out_pin, .o_crystal_osc_enable,
    .o_port_c_dir_bit0, .o_port_c_dir_bit1, .o_port_c_data_bit0,
    .o_port_c_data_bit1, .o_irq, .o_wake, .o_vector);

// ===== verification/gtimer_pin_model.sv
// Pin-side model: external count source, gate pin, comparator
module gtimer_pin_model (
    input wire logic i_mclk,
    output logic o_ext,
    output logic o_gate,
    output logic o_cmp
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_ext = 1'b0;
        o_gate = 1'b0;
        o_cmp = 1'b0;
    end
    task automatic set_lv(input logic g, input logic c);
        o_gate <= g;
        o_cmp <= c;
    endtask
    // Idles low; half sets the pace, slow or prompt
    task automatic pulse(input int n, input int half);
        repeat (n) begin
            @(posedge i_mclk);
            o_ext <= 1'b1;
            repeat (half) @(posedge i_mclk);
            o_ext <= 1'b0;
            repeat (half) @(posedge i_mclk);
        end
    endtask
endmodule // gtimer_pin_model

// ===== verification/tb_gated_sixteen_bit_timer.sv
// Self-checking bench for the gated sixteen bit timer
module tb_gated_sixteen_bit_timer;
    import gtimer_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_mclk, i_nrst, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, o_vector, q, r;
    logic xin, cap, slp, ext, gate, cmp, xout, osc, irq, wake, sev;
    logic dir0, dir1, dat0, dat1;
    logic [5:0] gt[6] = '{6'h20, 6'h01, 6'h25, 6'h07, 6'h39, 6'h37};
    int mismatches, checks, i;
    gated_sixteen_bit_timer dut (.i_mclk, .i_nrst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr,
        .i_external_count_input(ext), .i_crystal_osc_in_pin(xin),
        .i_gate_pin(gate), .i_synced_comparator_output(cmp),
        .i_capture_event(cap), .i_sleep(slp), .o_crystal_osc_out_pin(xout),
        .o_crystal_osc_enable(osc), .o_port_c_dir_bit0(dir0),
        .o_port_c_dir_bit1(dir1), .o_port_c_data_bit0(dat0),
        .o_port_c_data_bit1(dat1), .o_irq(irq), .o_wake(wake),
        .o_vector, .o_special_event(sev));
    gtimer_pin_model pins (.i_mclk, .o_ext(ext), .o_gate(gate), .o_cmp(cmp));
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h want %h", $time, s, x);
        end
    endtask
    // Pready is sampled, never assumed
    task automatic acc(input logic w, input logic [7:0] a, input int d);
        int n;
        @(posedge i_mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_mclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge i_mclk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        if (n == 16) begin
            mismatches++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wt(input logic s_irq, input int lim);
        int n;
        for (n = 0; n < lim; n++) begin
            @(posedge i_mclk);
            if ((s_irq ? irq : sev) === 1'b1) break;
        end
        if (n == lim) begin
            mismatches++;
            end_of_test();
        end
    endtask
    // Two snapshots a fixed span apart; phase of the divider cancels out
    task automatic rate(input int cyc);
        acc(0, ADDR_CNT_LO, 0);
        r = q;
        repeat (cyc - 3) @(posedge i_mclk);
        acc(0, ADDR_CNT_LO, 0);
        q = (q - r) & 32'hff;
    endtask
    initial begin
        {i_nrst, psel, penable, pwrite, xin, cap, slp} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (10) @(posedge i_mclk);
        i_nrst <= 1'b1;
        foreach (gt[k]) begin
            acc(0, 8'(4 * k), 0);
            chk(q, 0);
        end
        acc(1, ADDR_PORT, 32'h03);
        acc(1, ADDR_CTRL, 32'h08);
        @(negedge i_mclk);
        chk({dir1, dir0, dat1, dat0}, 4'hc);
        chk({osc, xout}, 2'b11);
        acc(1, ADDR_CTRL, 32'hf6);
        acc(0, ADDR_CTRL, 0);
        chk(q, 32'hf6);
        chk({dir1, dir0, dat1, dat0}, 4'h3);
        acc(0, 8'h24, 0);
        chk(e, 1'b1);
        $display("registers done");
        for (i = 0; i < 4; i++) begin
            acc(1, ADDR_CTRL, 1 | (i << 4));
            rate(64 << i);
            chk(q, 16);
        end
        acc(1, ADDR_CNT_LO, 0);
        acc(1, ADDR_CNT_HI, 32'h5a);
        acc(0, ADDR_CNT_HI, 0);
        chk(q, 32'h5a);
        acc(0, ADDR_CNT_LO, 0);
        chk(q, 0);
        $display("prescaler done");
        acc(1, ADDR_CTRL, 0);
        acc(1, ADDR_CNT_LO, 32'hff);
        acc(1, ADDR_CNT_HI, 32'hff);
        acc(1, ADDR_FLAGS, 32'h3);
        acc(1, ADDR_IEN, 32'h7);
        acc(1, ADDR_CTRL, 32'h1);
        wt(1, 40);
        chk(o_vector, ISR_VECTOR);
        chk(wake, 1'b1);
        acc(0, ADDR_FLAGS, 0);
        chk(q[0], 1'b1);
        acc(0, ADDR_CNT_HI, 0);
        chk(q, 0);
        acc(1, ADDR_IEN, 32'h6);
        repeat (2) @(posedge i_mclk);
        chk({irq, wake}, 2'b00);
        acc(1, ADDR_IEN, 32'h3);
        repeat (2) @(posedge i_mclk);
        chk({irq, wake}, 2'b01);
        acc(1, ADDR_CTRL, 0);
        repeat (2) @(posedge i_mclk);
        chk(wake, 1'b0);
        acc(1, ADDR_FLAGS, 32'h1);
        acc(0, ADDR_FLAGS, 0);
        chk(q[0], 1'b0);
        $display("overflow done");
        for (i = 0; i < 3; i++) begin
            acc(1, ADDR_CTRL, 0);
            slp <= (i != 0);
            acc(1, ADDR_CNT_LO, 0);
            acc(1, ADDR_CNT_HI, 0);
            acc(1, ADDR_CTRL, (i == 1) ? 32'h07 : 32'h03);
            pins.pulse(5, 4);
            acc(0, ADDR_CNT_LO, 0);
            chk(q, (i == 2) ? 0 : 4);
        end
        slp <= 1'b0;
        $display("external count done");
        foreach (gt[k]) begin
            acc(1, ADDR_GSEL, gt[k][4]);
            pins.set_lv(gt[k][2], gt[k][3]);
            acc(1, ADDR_CTRL, 1 | (gt[k][0] << 6) | (gt[k][1] << 7));
            rate(64);
            chk(q, gt[k][5] ? 16 : 0);
        end
        $display("gate done");
        acc(1, ADDR_CTRL, 0);
        acc(1, ADDR_CNT_LO, 32'h34);
        acc(1, ADDR_CNT_HI, 32'h02);
        acc(1, ADDR_CC_HI, 32'h100);
        cap <= 1'b1;
        @(posedge i_mclk);
        cap <= 1'b0;
        acc(0, ADDR_CC_LO, 0);
        chk(q, 32'h34);
        acc(0, ADDR_CC_HI, 0);
        chk(q & 32'hff, 32'h02);
        acc(1, ADDR_CC_LO, 32'h10);
        acc(1, ADDR_CC_HI, 32'h300);
        acc(1, ADDR_FLAGS, 32'h3);
        acc(1, ADDR_CNT_HI, 0);
        acc(1, ADDR_CNT_LO, 0);
        acc(1, ADDR_CTRL, 32'h1);
        wt(0, 120);
        acc(0, ADDR_CNT_LO, 0);
        chk(q < 32'h4, 1'b1);
        acc(0, ADDR_FLAGS, 0);
        chk(q[0], 1'b0);
        $display("capture compare done");
        end_of_test();
    end
endmodule // tb_gated_sixteen_bit_timer
